/* common/sox_pkg.sv */
// Constants for the single-operand, trap and bit-transfer execution unit.
// Assumes big-endian bit numbering in comments (bit 0 = MSB); code uses [15:0].
package sox_pkg;
  localparam logic [15:0] TRAP_VEC_BASE  = 16'h0040;
  localparam logic [15:0] VEC_PC_OFS     = 16'h0002;
  localparam logic [15:0] SRC_PLUS_TWO   = 16'h0002;
  localparam logic [3:0]  REG_LINK       = 4'hb;
  localparam logic [3:0]  REG_IO_BASE    = 4'hc;
  localparam logic [3:0]  REG_OLD_WP     = 4'hd;
  localparam logic [3:0]  REG_OLD_PC     = 4'he;
  localparam logic [3:0]  REG_OLD_ST     = 4'hf;
  // Status bit positions, as index into st[15:0] (bit 0 = st[15])
  localparam int ST_LGT  = 15;
  localparam int ST_AGT  = 14;
  localparam int ST_EQ   = 13;
  localparam int ST_CARRY = 12;
  localparam int ST_OVF  = 11;
  localparam int ST_PAR  = 10;
  localparam int ST_XOP  = 9;
  localparam logic [4:0]  FULL_WIDTH     = 5'h10;
  localparam logic [3:0]  BYTE_MAX       = 4'h8;
  localparam logic [15:0] RESET_WORD     = 16'h0000;
  // Operation codes of the single-operand group, opcode bits 0..9; trap and bit transfer groups, opcode bits 0..5
  localparam logic [9:0] OP_CONTEXT_SWITCH_BRANCH = 10'h010;
  localparam logic [9:0] OP_B    = 10'h011;
  localparam logic [9:0] OP_X    = 10'h012;
  localparam logic [9:0] OP_CLR  = 10'h013;
  localparam logic [9:0] OP_NEG  = 10'h014;
  localparam logic [9:0] OP_INV  = 10'h015;
  localparam logic [9:0] OP_INC  = 10'h016;
  localparam logic [9:0] OP_INCT = 10'h017;
  localparam logic [9:0] OP_DEC  = 10'h018;
  localparam logic [9:0] OP_DECT = 10'h019;
  localparam logic [9:0] OP_BL   = 10'h01a;
  localparam logic [9:0] OP_BYTE_SWAP_OP = 10'h01b;
  localparam logic [9:0] OP_SETO = 10'h01c;
  localparam logic [9:0] OP_ABS  = 10'h01d;
  localparam logic [5:0] OP_XOP  = 6'h0b;
  localparam logic [5:0] OP_BIT_IO_LOAD = 6'h0c;
  localparam logic [5:0] OP_BIT_IO_STORE = 6'h0d;
  typedef enum logic [3:0] {
    SOX_IDLE  = 4'h0,
    SOX_RD1   = 4'h1,
    SOX_RD2   = 4'h3,
    SOX_WR11  = 4'h2,
    SOX_WR13  = 4'h6,
    SOX_WR14  = 4'h7,
    SOX_WR15  = 4'h5,
    SOX_OPRD  = 4'h4,
    SOX_OPWR  = 4'hc,
    SOX_BITS  = 4'hd,
    SOX_BASE  = 4'hf,
    SOX_DONE  = 4'he
  } sox_state_t;
endpackage

/* common/sox_bit_if.sv */
// Link between the execution core and its serial bit shifter.
// Assumes both ends share clk_i and the synchronised reset.
`timescale 1ns/100ps
interface sox_bit_if;
  logic        start;
  logic        load_dir;
  logic [4:0]  count;
  logic [11:0] base;
  logic [15:0] wdata;
  logic        busy;
  logic        done;
  logic [15:0] rdata;
  modport core    (output start, load_dir, count, base, wdata, input busy, done, rdata);
  modport shifter (input start, load_dir, count, base, wdata, output busy, done, rdata);
endinterface

/* hdl/sox_bit_shift.sv */
// Serial bit shifter: moves bits one at a time to or from the bit I/O unit.
// Assumes bit_in_i is already synchronised by the top module.
`timescale 1ns/100ps
module sox_bit_shift
  import sox_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n,
  input  wire logic        ce_i,
  sox_bit_if.shifter       lnk,
  input  wire logic        bit_in_i,
  output logic [11:0]      bit_addr_o,
  output logic             bit_out_o,
  output logic             bit_wr_o,
  output logic             bit_rd_o
);
  logic [4:0]  left;
  logic [4:0]  pos;
  logic [15:0] sh;
  logic        dir;
  logic        running;
  logic [1:0]  ph;
  wire         last_bit  = (left == 5'h01);
  // Reads wait out the input synchroniser before sampling a bit
  wire         strobe_ph = (ph == (dir ? 2'd0 : 2'd2));
  wire         step_ph   = (ph == (dir ? 2'd1 : 2'd3));

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      left <= 5'h00; pos <= 5'h00; sh <= RESET_WORD; dir <= 1'b0;
      running <= 1'b0; lnk.done <= 1'b0; bit_addr_o <= 12'h000; ph <= 2'd0;
      bit_out_o <= 1'b0; bit_wr_o <= 1'b0; bit_rd_o <= 1'b0;
    end else if (ce_i) begin
      lnk.done <= 1'b0;
      bit_wr_o <= 1'b0;
      bit_rd_o <= 1'b0;
      if (lnk.start && !running) begin
        running    <= 1'b1;
        left       <= lnk.count;
        pos        <= 5'h00;
        ph         <= 2'd0;
        dir        <= lnk.load_dir;
        sh         <= lnk.load_dir ? lnk.wdata : RESET_WORD;
        bit_addr_o <= lnk.base;
      end else if (running) begin
        ph <= ph + 2'd1;
        if (strobe_ph && dir) begin
          bit_out_o <= sh[pos[3:0]];
          bit_wr_o  <= 1'b1;
        end
        if (strobe_ph && !dir) begin
          bit_rd_o <= 1'b1;
        end
        // Address moves only after the strobe has been seen with it
        if (step_ph) begin
          if (!dir) begin
            sh[pos[3:0]] <= bit_in_i;
          end
          ph         <= 2'd0;
          pos        <= pos + 5'h01;
          bit_addr_o <= bit_addr_o + 12'h001;
          left       <= left - 5'h01;
          if (last_bit) begin
            running  <= 1'b0;
            lnk.done <= 1'b1;
          end
        end
      end
    end
  end
  assign lnk.busy  = running;
  assign lnk.rdata = sh;
endmodule

/* hdl/sox_exec.sv */
// Execution unit for the trap, single-operand and multi-bit transfer groups.
// Assumes a simple memory port with one-cycle read data and a decoded source
// address supplied by the front end together with the instruction word.
`timescale 1ns/100ps
module sox_exec
  import sox_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        ce_i,
  input  wire logic        start_i,
  input  wire logic [15:0] instr_i,
  input  wire logic [15:0] src_addr_i,
  input  wire logic        src_autoinc_i,
  input  wire logic [3:0]  src_reg_i,
  input  wire logic [15:0] wp_i,
  input  wire logic [15:0] pc_i,
  input  wire logic [15:0] st_i,
  output logic [15:0]      mem_addr_o,
  output logic [15:0]      mem_wdata_o,
  output logic             mem_rd_o,
  output logic             mem_wr_o,
  output logic             mem_byte_o,
  input  wire logic [15:0] mem_rdata_i,
  output logic             fetch_strobe_o,
  output logic [15:0]      wp_o,
  output logic [15:0]      pc_o,
  output logic [15:0]      st_o,
  output logic             done_o,
  output logic             int_sample_o,
  output logic             exec_req_o,
  output logic [15:0]      exec_instr_o,
  output logic             reg_inc_o,
  output logic [3:0]       reg_inc_sel_o,
  output logic [15:0]      reg_inc_amt_o,
  input  wire logic        bit_in_i,
  output logic [11:0]      bit_addr_o,
  output logic             bit_out_o,
  output logic             bit_wr_o,
  output logic             bit_rd_o
);
  import sox_pkg::*;

  logic rst_s1, rst_n;
  logic bit_in_s1, bit_in_s2;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_s1 <= 1'b0; rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1; rst_n <= rst_s1;
    end
  end
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      bit_in_s1 <= 1'b0; bit_in_s2 <= 1'b0;
    end else if (ce_i) begin
      bit_in_s1 <= bit_in_i; bit_in_s2 <= bit_in_s1;
    end
  end

  sox_bit_if lnk();
  sox_bit_shift u_shift (
    .clk_i      (clk_i),
    .rst_n      (rst_n),
    .ce_i       (ce_i),
    .lnk        (lnk),
    .bit_in_i   (bit_in_s2),
    .bit_addr_o (bit_addr_o),
    .bit_out_o  (bit_out_o),
    .bit_wr_o   (bit_wr_o),
    .bit_rd_o   (bit_rd_o)
  );

  function automatic logic is_byte_width(input logic [3:0] c);
    is_byte_width = (c != 4'h0) && (c <= BYTE_MAX);
  endfunction

  // Decode
  wire [9:0]  op10    = instr_i[15:6];
  wire [5:0]  op6     = instr_i[15:10];
  wire [3:0]  wfield  = instr_i[9:6];
  wire        is_trap = (op6 == OP_XOP);
  wire        is_bits = (op6 == OP_BIT_IO_LOAD) || (op6 == OP_BIT_IO_STORE);
  wire        bits_ld = (op6 == OP_BIT_IO_LOAD);
  wire        narrow  = is_byte_width(wfield);
  wire [4:0]  nbits   = (wfield == 4'h0) ? FULL_WIDTH : {1'b0, wfield};
  wire [15:0] vec_wp  = TRAP_VEC_BASE + {10'h000, wfield, 2'b00};

  sox_state_t  state, next_state;
  logic [9:0]  op_q;
  logic [2:0]  kind; // 0 single-op, 1 trap, 2 bit transfer
  logic [15:0] opnd, new_wp, new_pc;
  logic        narrow_q, ld_q;

  // ALU for one-operand group
  wire [16:0] sum_inc  = {1'b0, opnd} + 17'h00001;
  wire [16:0] sum_inct = {1'b0, opnd} + 17'h00002;
  wire [16:0] sum_dec  = {1'b0, opnd} + 17'h1ffff;
  wire [16:0] sum_dect = {1'b0, opnd} + 17'h1fffe;
  wire [16:0] sum_neg  = {1'b0, ~opnd} + 17'h00001;
  wire [15:0] mag      = opnd[15] ? sum_neg[15:0] : opnd;
  logic [15:0] res;
  logic        cy, writes, arith, logic_only;
  always_comb begin
    res = opnd; cy = 1'b0; writes = 1'b1; arith = 1'b0; logic_only = 1'b0;
    case (op_q)
      OP_CLR:  res = 16'h0000;
      OP_SETO: res = 16'hffff;
      OP_INV:  begin res = ~opnd; logic_only = 1'b1; end
      OP_NEG:  begin res = sum_neg[15:0]; cy = sum_neg[16]; arith = 1'b1; end
      OP_ABS:  begin res = mag; cy = opnd[15] & sum_neg[16]; arith = 1'b1; end
      OP_INC:  begin res = sum_inc[15:0]; cy = sum_inc[16]; arith = 1'b1; end
      OP_INCT: begin res = sum_inct[15:0]; cy = sum_inct[16]; arith = 1'b1; end
      OP_DEC:  begin res = sum_dec[15:0]; cy = sum_dec[16]; arith = 1'b1; end
      OP_DECT: begin res = sum_dect[15:0]; cy = sum_dect[16]; arith = 1'b1; end
      OP_BYTE_SWAP_OP: res = {opnd[7:0], opnd[15:8]};
      default: writes = 1'b0;
    endcase
  end
  // Magnitude compares the original value; others the result
  wire [15:0] cmp_v  = (op_q == OP_ABS) ? opnd : res;
  wire        ovf    = arith && ((op_q == OP_INC || op_q == OP_INCT) ?
                       (!opnd[15] && res[15]) :
                       (op_q == OP_DEC || op_q == OP_DECT) ? (opnd[15] && !res[15]) :
                       (opnd == 16'h8000));
  logic [15:0] next_st;
  always_comb begin
    next_st = st_o;
    if (arith || logic_only) begin
      next_st[ST_LGT] = (cmp_v != 16'h0000);
      next_st[ST_AGT] = !cmp_v[15] && (cmp_v != 16'h0000);
      next_st[ST_EQ]  = (cmp_v == 16'h0000);
      if (arith) begin
        next_st[ST_CARRY] = cy;
        next_st[ST_OVF]   = ovf;
      end
    end
  end
  // Bit transfer status on the moved value
  wire [15:0] bit_val = ld_q ? lnk.wdata : lnk.rdata;
  wire [15:0] bit_cmp = narrow_q ? {bit_val[7:0], 8'h00} : bit_val;
  wire        bit_par = ^bit_val[7:0];

  always_comb begin
    next_state = state;
    case (state)
      SOX_IDLE:  if (start_i) next_state = SOX_RD1;
      SOX_RD1:   next_state = (kind == 3'd0 && (op_q == OP_CONTEXT_SWITCH_BRANCH)) ? SOX_RD2 :
                              (kind == 3'd1) ? SOX_RD2 :
                              (kind == 3'd2) ? SOX_BASE :
                              (op_q == OP_BL) ? SOX_WR11 : SOX_OPRD;
      SOX_RD2:   next_state = (kind == 3'd1) ? SOX_WR11 : SOX_WR13;
      SOX_WR11:  next_state = (kind == 3'd1) ? SOX_WR13 : SOX_DONE;
      SOX_WR13:  next_state = SOX_WR14;
      SOX_WR14:  next_state = SOX_WR15;
      SOX_WR15:  next_state = SOX_DONE;
      SOX_OPRD:  next_state = writes ? SOX_OPWR : SOX_DONE;
      SOX_OPWR:  next_state = SOX_DONE;
      SOX_BITS:  if (lnk.done) next_state = ld_q ? SOX_DONE : SOX_OPWR;
      SOX_BASE:  next_state = SOX_BITS;
      SOX_DONE:  next_state = SOX_IDLE;
      default:   next_state = SOX_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= SOX_IDLE; op_q <= 10'h000; kind <= 3'd0; opnd <= RESET_WORD;
      new_wp <= RESET_WORD; new_pc <= RESET_WORD; narrow_q <= 1'b0; ld_q <= 1'b0;
      mem_addr_o <= RESET_WORD; mem_wdata_o <= RESET_WORD; mem_rd_o <= 1'b0;
      mem_wr_o <= 1'b0; mem_byte_o <= 1'b0; fetch_strobe_o <= 1'b0;
      wp_o <= RESET_WORD; pc_o <= RESET_WORD; st_o <= RESET_WORD;
      done_o <= 1'b0; int_sample_o <= 1'b0; exec_req_o <= 1'b0;
      exec_instr_o <= RESET_WORD; reg_inc_o <= 1'b0; reg_inc_sel_o <= 4'h0;
      reg_inc_amt_o <= RESET_WORD; lnk.start <= 1'b0; lnk.load_dir <= 1'b0;
      lnk.count <= 5'h00; lnk.base <= 12'h000; lnk.wdata <= RESET_WORD;
    end else if (ce_i) begin
      state <= next_state;
      mem_rd_o <= 1'b0; mem_wr_o <= 1'b0; done_o <= 1'b0; int_sample_o <= 1'b0;
      exec_req_o <= 1'b0; reg_inc_o <= 1'b0; lnk.start <= 1'b0;
      fetch_strobe_o <= 1'b0;
      case (state)
        SOX_IDLE: if (start_i) begin
          op_q <= op10; wp_o <= wp_i; pc_o <= pc_i; st_o <= st_i;
          kind <= is_trap ? 3'd1 : is_bits ? 3'd2 : 3'd0;
          narrow_q <= is_bits && narrow; ld_q <= bits_ld;
          mem_rd_o <= 1'b1;
          mem_byte_o <= is_bits && narrow;
          mem_addr_o <= is_trap ? vec_wp : is_bits ? src_addr_i :
                        (op10 == OP_BL || op10 == OP_B) ? src_addr_i : src_addr_i;
          if (src_autoinc_i && !is_trap) begin
            reg_inc_o     <= 1'b1;
            reg_inc_sel_o <= src_reg_i;
            reg_inc_amt_o <= (is_bits && narrow) ? 16'h0001 : 16'h0002;
          end
          if (is_bits) begin
            lnk.count    <= nbits;
            lnk.load_dir <= bits_ld;
          end
          new_pc <= src_addr_i;
        end
        SOX_RD1: begin
          opnd   <= mem_rdata_i;
          new_wp <= mem_rdata_i;
          if (kind == 3'd1) begin
            mem_rd_o <= 1'b1; mem_addr_o <= vec_wp + VEC_PC_OFS;
          end else if (op_q == OP_CONTEXT_SWITCH_BRANCH && kind == 3'd0) begin
            mem_rd_o <= 1'b1; mem_addr_o <= new_pc + SRC_PLUS_TWO;
          end else if (kind == 3'd2) begin
            // Base register read: its offset in the workspace
            lnk.wdata <= narrow_q ? {8'h00, mem_rdata_i[15:8]} : mem_rdata_i;
            mem_rd_o <= 1'b1; mem_byte_o <= 1'b0;
            mem_addr_o <= wp_o + {11'h000, REG_IO_BASE, 1'b0};
          end else if (op_q == OP_X) begin
            // Target word goes to the front end as the current instruction
            exec_instr_o <= mem_rdata_i;
          end
        end
        SOX_RD2: begin
          wp_o <= new_wp; pc_o <= mem_rdata_i;
          if (kind == 3'd1) st_o[ST_XOP] <= 1'b1;
        end
        SOX_WR11: begin
          mem_wr_o <= 1'b1;
          mem_byte_o <= 1'b0;
          mem_addr_o <= wp_o + {11'h000, REG_LINK, 1'b0};
          mem_wdata_o <= (kind == 3'd1) ? new_pc : pc_o;
          if (kind == 3'd0) pc_o <= new_pc;
        end
        SOX_WR13: begin
          mem_wr_o <= 1'b1; mem_byte_o <= 1'b0;
          mem_addr_o <= wp_o + {11'h000, REG_OLD_WP, 1'b0};
          mem_wdata_o <= wp_i;
        end
        SOX_WR14: begin
          mem_wr_o <= 1'b1;
          mem_addr_o <= wp_o + {11'h000, REG_OLD_PC, 1'b0};
          mem_wdata_o <= pc_i;
        end
        SOX_WR15: begin
          mem_wr_o <= 1'b1;
          mem_addr_o <= wp_o + {11'h000, REG_OLD_ST, 1'b0};
          mem_wdata_o <= st_i;
        end
        SOX_OPRD: begin
          if (op_q == OP_B) pc_o <= new_pc;
          if (writes) begin
            mem_wr_o <= 1'b1; mem_addr_o <= new_pc; mem_wdata_o <= res;
            st_o <= next_st;
          end
        end
        SOX_BASE: begin
          lnk.base <= mem_rdata_i[12:1];
        end
        SOX_BITS: begin
          if (!lnk.busy && !lnk.done) begin
            lnk.start <= 1'b1;
          end
          if (lnk.done) begin
            st_o[ST_LGT] <= (bit_cmp != 16'h0000);
            st_o[ST_AGT] <= !bit_cmp[15] && (bit_cmp != 16'h0000);
            st_o[ST_EQ]  <= (bit_cmp == 16'h0000);
            if (narrow_q) st_o[ST_PAR] <= bit_par;
            if (!ld_q) begin
              mem_wr_o <= 1'b1; mem_addr_o <= new_pc;
              mem_byte_o <= narrow_q;
              mem_wdata_o <= narrow_q ? {lnk.rdata[7:0], 8'h00} : lnk.rdata;
            end
          end
        end
        SOX_DONE: begin
          done_o <= 1'b1;
          exec_req_o <= (kind == 3'd0) && (op_q == OP_X);
          int_sample_o <= !((kind == 3'd1) || (op_q == OP_CONTEXT_SWITCH_BRANCH && kind == 3'd0));
        end
        default: ;
      endcase
    end
  end

  trap_flag_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    (state == SOX_RD2 && kind == 3'd1 && ce_i) |=> st_o[ST_XOP])
    else $error("trap flag not set");
  no_int_trap_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    (done_o && (kind == 3'd1 || op_q == OP_CONTEXT_SWITCH_BRANCH)) |-> !int_sample_o)
    else $error("interrupt sampled after trap or context switch");
  swap_val_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    (state == SOX_OPRD && op_q == OP_BYTE_SWAP_OP && ce_i) |=>
    (mem_wdata_o == {$past(opnd[7:0]), $past(opnd[15:8])}) && st_o == $past(st_o))
    else $error("byte swap wrong");
  abs_cmp_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    (state == SOX_OPRD && op_q == OP_ABS && ce_i) |=> st_o[ST_EQ] == ($past(opnd) == 16'h0000))
    else $error("magnitude compare wrong");
  no_fetch_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    mem_rd_o |-> !fetch_strobe_o)
    else $error("fetch strobe during operand read");
  auto_inc_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    (reg_inc_o && kind == 3'd2) |-> reg_inc_amt_o == (narrow_q ? 16'h0001 : 16'h0002))
    else $error("auto increment amount wrong");
  par_keep_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    (state == SOX_BITS && lnk.done && !narrow_q && ce_i) |=> $stable(st_o[ST_PAR]))
    else $error("parity touched for wide transfer");
  bits_done_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    (lnk.start && ce_i) |-> ##[1:80] lnk.done)
    else $error("bit transfer did not finish");
endmodule

/* dv/sox_mem_io_model.sv */
// Memory and bit I/O peripheral model facing the execution unit.
// Assumes one-cycle read data, byte lanes in bits 15:8, words at address 15:1.
`timescale 1ns/100ps
module sox_mem_io_model (
  input  wire logic        clk_i,
  input  wire logic [15:0] mem_addr_i,
  input  wire logic [15:0] mem_wdata_i,
  input  wire logic        mem_rd_i,
  input  wire logic        mem_wr_i,
  input  wire logic        mem_byte_i,
  output logic      [15:0] mem_rdata_o,
  input  wire logic [11:0] bit_addr_i,
  input  wire logic        bit_out_i,
  input  wire logic        bit_wr_i,
  input  wire logic        bit_rd_i,
  output logic             bit_in_o
);
  logic [15:0] mem [0:32767];
  logic        io_pat [0:4095];
  int          wq[$];
  int          rq[$];
  logic [15:0] w;
  initial begin
    for (int i = 0; i < 32768; i++)
      mem[i] = 16'(i * 40503);
    for (int i = 0; i < 4096; i++)
      io_pat[i] = i[0] ^ i[3] ^ i[6];
  end
  // Read data stands while the read strobe does; released bus shows the inverse
  always @* begin
    w = mem[mem_addr_i[15:1]];
    if (mem_rd_i)
      mem_rdata_o = (mem_byte_i && mem_addr_i[0]) ? {w[7:0], w[15:8]} : w;
    else
      mem_rdata_o = ~w;
  end
  always @(posedge clk_i) begin
    if (mem_wr_i && !mem_byte_i)
      mem[mem_addr_i[15:1]] <= mem_wdata_i;
    else if (mem_wr_i && mem_addr_i[0])
      mem[mem_addr_i[15:1]][7:0] <= mem_wdata_i[15:8];
    else if (mem_wr_i)
      mem[mem_addr_i[15:1]][15:8] <= mem_wdata_i[15:8];
    if (bit_wr_i)
      wq.push_back({bit_addr_i, bit_out_i});
    if (bit_rd_i)
      rq.push_back(int'(bit_addr_i));
  end
  // Input line follows the held address; the peripheral is always selected
  assign bit_in_o = io_pat[bit_addr_i];
endmodule

/* dv/test_single_operand_and_cru_exec.sv */
// Self-checking bench for the trap, single-operand and bit-transfer unit.
// Assumes sox_exec as unit under test beside a memory and bit I/O model.
`timescale 1ns/100ps
module test_single_operand_and_cru_exec;
  import sox_pkg::*;
  logic        clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic        ce_i = 1'b1;
  logic        start_i = 1'b0;
  logic        src_autoinc_i = 1'b0;
  logic [3:0]  src_reg_i = 4'h0;
  logic [15:0] instr_i = 16'h0000;
  logic [15:0] src_addr_i = 16'h0000;
  logic [15:0] wp_i = 16'h0000;
  logic [15:0] pc_i = 16'h0000;
  logic [15:0] st_i = 16'h0000;
  logic [15:0] mem_rdata_i, mem_addr_o, mem_wdata_o, wp_o, pc_o, st_o, exec_instr_o;
  logic [15:0] reg_inc_amt_o, wp, pc, st, inc_amt;
  logic        mem_rd_o, mem_wr_o, mem_byte_o, fetch_strobe_o, done_o, int_sample_o;
  logic        exec_req_o, reg_inc_o, bit_out_o, bit_wr_o, bit_rd_o, bit_in_i, opb;
  logic [3:0]  reg_inc_sel_o, inc_sel;
  logic [11:0] bit_addr_o;
  logic [9:0]  ops [10] = '{OP_CLR, OP_SETO, OP_INV, OP_NEG, OP_INC, OP_INCT, OP_DEC,
                            OP_DECT, OP_BYTE_SWAP_OP, OP_ABS};
  int          fail_count = 0, samples_checked = 0, cyc = 0, inc_n = 0, fs_hi = 0;
  int          seed = 32'h55ecb277;

  sox_exec dut (.clk_i, .nrst_i, .ce_i, .start_i, .instr_i, .src_addr_i, .src_autoinc_i,
    .src_reg_i, .wp_i, .pc_i, .st_i, .mem_addr_o, .mem_wdata_o, .mem_rd_o, .mem_wr_o,
    .mem_byte_o, .mem_rdata_i, .fetch_strobe_o, .wp_o, .pc_o, .st_o, .done_o,
    .int_sample_o, .exec_req_o, .exec_instr_o, .reg_inc_o, .reg_inc_sel_o, .reg_inc_amt_o,
    .bit_in_i, .bit_addr_o, .bit_out_o, .bit_wr_o, .bit_rd_o);
  sox_mem_io_model pm (.clk_i, .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o),
    .mem_rd_i(mem_rd_o), .mem_wr_i(mem_wr_o), .mem_byte_i(mem_byte_o),
    .mem_rdata_o(mem_rdata_i), .bit_addr_i(bit_addr_o), .bit_out_i(bit_out_o),
    .bit_wr_i(bit_wr_o), .bit_rd_i(bit_rd_o), .bit_in_o(bit_in_i));

  always #2.5 clk_i = ~clk_i;

  always @(posedge clk_i) begin
    cyc++;
    if (reg_inc_o === 1'b1) begin
      inc_n++;
      inc_sel = reg_inc_sel_o;
      inc_amt = reg_inc_amt_o;
    end
    if (mem_rd_o === 1'b1 && mem_addr_o === src_addr_i)
      opb = mem_byte_o;
    if (fetch_strobe_o !== 1'b0 && nrst_i)
      fs_hi++;
    // Ceiling well above the expected few thousand cycles
    if (cyc == 20000) begin
      fail_count++;
      finish_test();
    end
  end

  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  function automatic logic [15:0] rw();
    return 16'($random(seed));
  endfunction

  function automatic logic [15:0] mr(input logic [15:0] a);
    return pm.mem[a[15:1]];
  endfunction

  task automatic mw(input logic [15:0] a, input logic [15:0] v);
    pm.mem[a[15:1]] = v;
  endtask

  function automatic logic [15:0] op_ref(input logic [9:0] op, input logic [15:0] x);
    case (op)
      OP_CLR:  return 16'h0000;
      OP_SETO: return 16'hffff;
      OP_INV:  return ~x;
      OP_NEG:  return -x;
      OP_INC:  return x + 16'h0001;
      OP_INCT: return x + 16'h0002;
      OP_DEC:  return x - 16'h0001;
      OP_DECT: return x - 16'h0002;
      OP_BYTE_SWAP_OP: return {x[7:0], x[15:8]};
      default: return x[15] ? -x : x;
    endcase
  endfunction

  // Launch one instruction and wait for its completion pulse
  task automatic run(input logic [15:0] ins, input logic [15:0] sa, input logic ai);
    int k;
    pm.wq.delete();
    pm.rq.delete();
    inc_n = 0;
    @(posedge clk_i);
    start_i <= 1'b1;
    instr_i <= ins;
    src_addr_i <= sa;
    src_autoinc_i <= ai;
    src_reg_i <= ins[3:0];
    wp_i <= wp;
    pc_i <= pc;
    st_i <= st;
    @(posedge clk_i);
    start_i <= 1'b0;
    k = 0;
    do begin
      @(negedge clk_i);
      k++;
    end while (done_o !== 1'b1 && k < 300);
    if (k >= 300)
      chk(16'h0000, 16'h0001, "no completion");
  endtask

  initial begin
    int n;
    logic [15:0] sa, nw, v, e, res, w12, opnd;
    logic [11:0] base;
    logic        byt, ai;
    repeat (5) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    for (int d = 0; d < 16; d++) begin
      wp = 16'h1000 | (rw() & 16'h07fe);
      pc = rw() & 16'hfffe;
      st = rw();
      sa = 16'h4000 | (rw() & 16'h0ffe);
      nw = 16'h2000 + 16'(d * 64);
      mw(16'h0040 + 16'(4 * d), nw);
      mw(16'h0042 + 16'(4 * d), pc ^ 16'h8000);
      run({OP_XOP, 4'(d), 6'h00}, sa, 1'b0);
      e = st;
      e[ST_XOP] = 1'b1;
      chk(wp_o, nw, "trap pointer");
      chk(pc_o, pc ^ 16'h8000, "trap counter");
      chk(st_o, e, "trap status");
      chk(16'(int_sample_o), 16'h0000, "trap sampling");
      chk(mr(nw + 16'd22), sa, "trap r11");
      chk(mr(nw + 16'd26), wp, "trap r13");
      chk(mr(nw + 16'd28), pc, "trap r14");
      chk(mr(nw + 16'd30), st, "trap r15");
      nw = 16'h3000 | (rw() & 16'h0fde);
      mw(sa, nw);
      mw(sa + 16'd2, ~pc);
      run({OP_CONTEXT_SWITCH_BRANCH, 6'h00}, sa, 1'b0);
      chk(wp_o, nw, "switch pointer");
      chk(pc_o, ~pc, "switch counter");
      chk(mr(nw + 16'd26), wp, "switch r13");
      chk(mr(nw + 16'd28), pc, "switch r14");
      chk(mr(nw + 16'd30), st, "switch r15");
      chk(16'(int_sample_o), 16'h0000, "switch sampling");
      run({OP_B, 6'h00}, sa, 1'b0);
      chk(pc_o, sa, "branch");
      run({OP_BL, 6'h00}, sa ^ 16'h0100, 1'b0);
      chk(pc_o, sa ^ 16'h0100, "link branch");
      chk(mr(wp + 16'd22), pc, "link save");
      fs_hi = 0;
      run({OP_X, 6'h00}, sa + 16'd2, 1'b0);
      chk(16'(exec_req_o), 16'h0001, "execute request");
      chk(exec_instr_o, ~pc, "execute target");
      chk(pc_o, pc, "execute counter");
      chk(16'(fs_hi), 16'h0000, "fetch strobe");
      v = (d == 0) ? 16'h0000 : (d == 1) ? 16'h8000 : rw();
      for (int i = 0; i < 10; i++) begin
        mw(sa, v);
        run({ops[i], 6'h00}, sa, 1'b0);
        chk(mr(sa), op_ref(ops[i], v), "single result");
        if (ops[i] == OP_BYTE_SWAP_OP)
          chk(st_o, st, "swap status");
        if (ops[i] == OP_ABS)
          chk(16'(st_o[15:13]), {13'h0, v != 0, $signed(v) > 0, v == 0}, "abs status");
      end
    end
    for (int j = 0; j < 32; j++) begin
      n = (j % 16 == 0) ? 16 : j % 16;
      byt = (n <= 8);
      ai = j[1];
      wp = 16'h1000 | (rw() & 16'h07fe);
      st = rw();
      sa = 16'h4000 | (rw() & 16'h0ffe);
      w12 = rw();
      base = w12[12:1];
      mw(wp + 16'd24, w12);
      v = rw();
      mw(sa, v);
      opnd = byt ? {8'h00, v[15:8]} : v;
      res = 16'h0000;
      run({j < 16 ? OP_BIT_IO_LOAD : OP_BIT_IO_STORE, 4'(j), ai ? 2'b11 : 2'b00, 4'(rw())}, sa, ai);
      chk(16'(opb), 16'(byt), "operand size");
      chk(mr(wp + 16'd24), w12, "base kept");
      if (ai) begin
        chk(16'(inc_n), 16'h0001, "increment count");
        chk(16'(inc_sel), 16'(instr_i[3:0]), "increment reg");
        chk(inc_amt, byt ? 16'h0001 : 16'h0002, "increment size");
      end
      if (j < 16) begin
        chk(16'(pm.wq.size()), 16'(n), "load bits");
        for (int i = 0; i < n && i < pm.wq.size(); i++)
          chk(16'(pm.wq[i]), {3'b000, 12'(base + i), opnd[i]}, "load bit");
        res = opnd;
      end else begin
        chk(16'(pm.rq.size()), 16'(n), "store bits");
        for (int i = 0; i < n; i++)
          res[i] = pm.io_pat[12'(base + i)];
        for (int i = 0; i < n && i < pm.rq.size(); i++)
          chk(16'(pm.rq[i]), 16'(12'(base + i)), "store addr");
        chk(mr(sa), byt ? {res[7:0], v[7:0]} : res, "store value");
      end
      chk(16'(st_o[ST_PAR]), 16'(byt ? ^res[7:0] : st[ST_PAR]), "parity");
    end
    finish_test();
  end
endmodule
